// ---- gds_diag.sv ----
// diagnosis code, move check and status lamp logic of the gripper
`timescale 1ns/1ps
module gds_diag #(
    parameter int           HALF_CYCLES = gds_pkg::BLINK_HALF_CYC,
    parameter logic [7:0]   WP_LIMIT    = gds_pkg::WP_MAX
) (
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // motion commands and process data
    input  wire logic               move_req,
    input  wire logic               move_dir,
    input  wire logic               err_reset,
    input  wire logic               dir_flag_reset,
    input  wire logic               handshake,
    input  wire gds_pkg::gds_pd_type pd_in,
    // fault and condition levels from the gripper core
    input  wire logic               jaw_blocked,
    input  wire logic               block_ack,
    input  wire logic               sys_error,
    input  wire logic               int_error,
    input  wire logic               no_prod_params,
    input  wire logic               workpiece_lost,
    input  wire logic               supply_bad,
    input  wire logic               no_reference,
    input  wire logic               ref_running,
    input  wire logic               link_only,
    input  wire logic               pd_invalid,
    // results
    output logic                    move_accept,
    output logic [15:0]             diag_code,
    output logic                    led_red,
    output logic                    led_green,
    output logic                    irq,
    // register port
    input  wire logic [7:0]         addr,
    input  wire logic [31:0]        wr_data,
    input  wire logic               wr_en,
    input  wire logic               rd_en,
    output logic [31:0]             rd_data
);
    // ****************************************************************
    // register decode
    // ****************************************************************
    wire wr_ctrl  = wr_en && addr == gds_pkg::OFS_CTRL;
    wire wr_clear = wr_en && addr == gds_pkg::OFS_CLEAR;
    wire wr_enab  = wr_en && addr == gds_pkg::OFS_ENABLE;
    wire any_err_rst = err_reset
        || (wr_ctrl && wr_data[gds_pkg::CTRL_ERR_RST]);
    wire any_dir_rst = dir_flag_reset
        || (wr_ctrl && wr_data[gds_pkg::CTRL_DIR_RST]);
    wire any_blk_ack = block_ack
        || (wr_ctrl && wr_data[gds_pkg::CTRL_BLK_ACK]);

    // ****************************************************************
    // move command check
    // ****************************************************************
    logic dir_valid_reg;
    logic last_dir_reg;
    logic refuse_reg;
    logic blocked_reg;
    logic range_reg;
    logic boot_reg;
    gds_pkg::gds_pd_type applied_reg;

    // internal faults are levels; blockage latches until acknowledged or error reset
    wire fault_int   = sys_error || int_error || no_prod_params;
    wire err_pending = fault_int || blocked_reg;
    wire same_dir    = dir_valid_reg && move_dir == last_dir_reg;
    wire refuse_now  = move_req && (err_pending || same_dir);
    wire accept_now  = move_req && !refuse_now;

    // direction memory; opposite move, error or flag reset all free it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dir_valid_reg <= 1'b0;
            last_dir_reg  <= 1'b0;
        end else if (accept_now) begin
            dir_valid_reg <= 1'b1;
            last_dir_reg  <= move_dir;
        end else if (any_err_rst || any_dir_rst) begin
            dir_valid_reg <= 1'b0;
        end
    end

    // refusal code stays until the flag is freed or a move succeeds
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            refuse_reg  <= 1'b0;
            move_accept <= 1'b0;
        end else begin
            refuse_reg  <= refuse_now
                || (refuse_reg && !accept_now && !any_err_rst
                    && !any_dir_rst);
            move_accept <= accept_now;
        end
    end

    // blockage: a new blockage wins over an acknowledge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            blocked_reg <= 1'b0;
        end else begin
            blocked_reg <= jaw_blocked
                || (blocked_reg && !any_blk_ack && !any_err_rst);
        end
    end

    // ****************************************************************
    // process data handshake
    // ****************************************************************
    wire wp_bad = pd_in.workpiece_index > WP_LIMIT;

    // out-of-range index is kept out of the applied copy
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            applied_reg <= '0;
            range_reg   <= 1'b0;
            boot_reg    <= 1'b1;
        end else if (handshake) begin
            applied_reg <= pd_in;
            if (wp_bad) begin
                applied_reg.workpiece_index <= applied_reg.workpiece_index;
            end
            range_reg <= wp_bad;
            boot_reg  <= 1'b0;
        end
    end

    // items written but not yet taken over
    wire chg_pos = pd_in.taught_jaw_position
        != applied_reg.taught_jaw_position;
    wire chg_frc = pd_in.clamp_force_setting
        != applied_reg.clamp_force_setting;
    wire chg_win = pd_in.taught_position_window
        != applied_reg.taught_position_window;
    wire chg_prf = pd_in.profile_select != applied_reg.profile_select;
    wire chg_wp  = !range_reg
        && pd_in.workpiece_index != applied_reg.workpiece_index;

    // ****************************************************************
    // diagnosis code selection
    // ****************************************************************
    logic [15:0] code_next;

    // internal faults first, then movement, then process data
    always_comb begin
        if (sys_error)           code_next = gds_pkg::CODE_SYS_ERR;
        else if (int_error)      code_next = gds_pkg::CODE_INT_ERR;
        else if (no_prod_params) code_next = gds_pkg::CODE_NO_PROD;
        else if (blocked_reg)    code_next = gds_pkg::CODE_BLOCKED;
        else if (refuse_reg)     code_next = gds_pkg::CODE_MOVE_REF;
        else if (range_reg)      code_next = gds_pkg::CODE_WP_RANGE;
        else if (boot_reg)       code_next = gds_pkg::CODE_RESTART;
        else if (chg_pos)        code_next = gds_pkg::CODE_CHG_POS;
        else if (chg_frc)        code_next = gds_pkg::CODE_CHG_FRC;
        else if (chg_win)        code_next = gds_pkg::CODE_CHG_WIN;
        else if (chg_prf)        code_next = gds_pkg::CODE_CHG_PRF;
        else if (chg_wp)         code_next = gds_pkg::CODE_CHG_WP;
        else                     code_next = gds_pkg::CODE_READY;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) diag_code <= gds_pkg::CODE_RESTART;
        else     diag_code <= code_next;
    end

    // ****************************************************************
    // shared blinker and lamp patterns
    // ****************************************************************
    logic [31:0] blink_cnt_reg;
    logic        blink_reg;
    wire blink_wrap = blink_cnt_reg == 32'(HALF_CYCLES - 1);

    // one phase source keeps in-phase and alternate patterns aligned
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            blink_cnt_reg <= 32'h0;
            blink_reg     <= 1'b0;
        end else if (blink_wrap) begin
            blink_cnt_reg <= 32'h0;
            blink_reg     <= !blink_reg;
        end else begin
            blink_cnt_reg <= blink_cnt_reg + 32'h1;
        end
    end

    gds_pkg::gds_lamp_type lamp;
    // most severe condition chooses the pattern
    always_comb begin
        if (fault_int)                    lamp = gds_pkg::LAMP_INT_ERR;
        else if (supply_bad)              lamp = gds_pkg::LAMP_SUPPLY;
        else if (ref_running)             lamp = gds_pkg::LAMP_REF_RUN;
        else if (no_reference)            lamp = gds_pkg::LAMP_NO_REF;
        else if (link_only && pd_invalid) lamp = gds_pkg::LAMP_PD_BAD;
        else if (workpiece_lost)          lamp = gds_pkg::LAMP_WP_LOST;
        else                              lamp = gds_pkg::LAMP_OK;
    end

    logic red_next;
    logic green_next;
    always_comb begin
        case (lamp)
            gds_pkg::LAMP_INT_ERR: begin
                red_next = blink_reg; green_next = 1'b0;
            end
            gds_pkg::LAMP_SUPPLY: begin
                red_next = 1'b1; green_next = 1'b0;
            end
            gds_pkg::LAMP_REF_RUN: begin
                red_next = blink_reg; green_next = !blink_reg;
            end
            gds_pkg::LAMP_NO_REF: begin
                red_next = blink_reg; green_next = blink_reg;
            end
            gds_pkg::LAMP_PD_BAD: begin
                red_next = blink_reg; green_next = 1'b1;
            end
            gds_pkg::LAMP_WP_LOST: begin
                red_next = blink_reg; green_next = 1'b1;
            end
            default: begin
                red_next = 1'b0; green_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            led_red   <= 1'b0;
            led_green <= 1'b0;
        end else begin
            led_red   <= red_next;
            led_green <= green_next;
        end
    end

    // ****************************************************************
    // interrupt status and register reads
    // ****************************************************************
    logic [gds_pkg::EVW-1:0] stat_reg;
    logic [gds_pkg::EVW-1:0] enable_reg;
    logic                    fault_d_reg;
    logic [gds_pkg::EVW-1:0] ev;

    assign ev[gds_pkg::EV_REFUSE] = refuse_now;
    assign ev[gds_pkg::EV_RANGE]  = handshake && wp_bad;
    assign ev[gds_pkg::EV_BLOCK]  = jaw_blocked && !blocked_reg;
    assign ev[gds_pkg::EV_FAULT]  = fault_int && !fault_d_reg;
    assign ev[gds_pkg::EV_CODE]   = code_next != diag_code;

    // a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stat_reg    <= gds_pkg::EV_RESET;
            enable_reg  <= gds_pkg::EV_RESET;
            fault_d_reg <= 1'b0;
        end else begin
            stat_reg <= ev | (stat_reg
                & ~(wr_clear ? wr_data[gds_pkg::EVW-1:0] : '0));
            if (wr_enab) enable_reg <= wr_data[gds_pkg::EVW-1:0];
            fault_d_reg <= fault_int;
        end
    end

    assign irq = |(stat_reg & enable_reg);

    logic [31:0] rd_next;
    always_comb begin
        case (addr)
            gds_pkg::OFS_DIAG:   rd_next = {16'h0, diag_code};
            gds_pkg::OFS_STAT:   rd_next = 32'(stat_reg);
            gds_pkg::OFS_ENABLE: rd_next = 32'(enable_reg);
            gds_pkg::OFS_FLAGS:  rd_next = {26'h0, led_green, led_red,
                boot_reg, blocked_reg, last_dir_reg, dir_valid_reg};
            default:             rd_next = 32'h0;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (rst)        rd_data <= 32'h0;
        else if (rd_en) rd_data <= rd_next;
        else            rd_data <= 32'h0;
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence same_move_s;
        move_req && dir_valid_reg && move_dir == last_dir_reg;
    endsequence

    same_dir_refused_a: assert property (same_move_s |=> !move_accept
        ##1 diag_code == gds_pkg::CODE_MOVE_REF || err_pending)
        else $error("same direction move was not refused");
    err_move_refused_a: assert property (move_req && err_pending
        |=> !move_accept)
        else $error("move accepted while error pending");
    dir_flag_free_a: assert property ((any_dir_rst || any_err_rst)
        && !move_req |=> !dir_valid_reg)
        else $error("direction flag not freed");
    wp_range_code_a: assert property (handshake && wp_bad && !fault_int
        && !jaw_blocked && !blocked_reg && !refuse_now && !refuse_reg
        |=> ##1 diag_code == gds_pkg::CODE_WP_RANGE)
        else $error("range code not reported");
    boot_code_a: assert property (boot_reg && !err_pending && !refuse_reg
        && !range_reg |=> diag_code == gds_pkg::CODE_RESTART)
        else $error("restart code missing");
    blocked_hold_a: assert property (blocked_reg && !any_blk_ack
        && !any_err_rst && !fault_int |=> diag_code
        == gds_pkg::CODE_BLOCKED)
        else $error("blockage code dropped");
    sys_code_a: assert property (sys_error |=>
        diag_code == gds_pkg::CODE_SYS_ERR)
        else $error("system error code missing");
    ready_green_a: assert property (lamp == gds_pkg::LAMP_OK
        |=> led_green && !led_red)
        else $error("ready lamp wrong");
    supply_red_a: assert property (!fault_int && supply_bad
        |=> led_red && !led_green)
        else $error("supply lamp wrong");
    alt_flash_a: assert property (lamp == gds_pkg::LAMP_REF_RUN
        |=> led_red != led_green)
        else $error("reference run lamps not alternating");
    inphase_a: assert property (lamp == gds_pkg::LAMP_NO_REF
        |=> led_red == led_green)
        else $error("no reference lamps not in phase");
    blink_period_a: assert property (blink_wrap
        |=> blink_reg != $past(blink_reg) && blink_cnt_reg == 32'h0)
        else $error("blinker phase wrong");
endmodule : gds_diag

// ---- gds_pkg.sv ----
// constants and types of the gripper diagnosis and status lamp block
// ****************************************************************
// How it works
// - refuse same-direction move or move during error; report 0x0307
// - direction flag cleared by opposite move, error reset, flag reset
// - out-of-range workpiece index not selected; report 0x0308
// - changed item not taken over by handshake reports its own code
// - after restart report 0x0312 until first handshake
// - jaw blockage reports 0x0400 until acknowledged
// - 0x0406 system error, 0x040b internal, 0x0411 no production data
// - no error: green steady, red dark
// - workpiece loss: red flashes 1 s, green steady
// - actuator supply bad: red steady
// - internal error: red flashes 1 s, green off
// - no reference position: red and green flash in phase
// - reference run: red and green flash alternately
// - link-only variant: invalid process data flashes red
// - ready with no error reports 0x0000
// ****************************************************************
package gds_pkg;
    // diagnosis codes
    localparam logic [15:0] CODE_READY    = 16'h0000;
    localparam logic [15:0] CODE_MOVE_REF = 16'h0307;
    localparam logic [15:0] CODE_WP_RANGE = 16'h0308;
    localparam logic [15:0] CODE_CHG_POS  = 16'h0309;
    localparam logic [15:0] CODE_CHG_FRC  = 16'h030d;
    localparam logic [15:0] CODE_CHG_WIN  = 16'h030f;
    localparam logic [15:0] CODE_CHG_PRF  = 16'h0310;
    localparam logic [15:0] CODE_CHG_WP   = 16'h0311;
    localparam logic [15:0] CODE_RESTART  = 16'h0312;
    localparam logic [15:0] CODE_BLOCKED  = 16'h0400;
    localparam logic [15:0] CODE_SYS_ERR  = 16'h0406;
    localparam logic [15:0] CODE_INT_ERR  = 16'h040b;
    localparam logic [15:0] CODE_NO_PROD  = 16'h0411;
    // workpiece index limit
    localparam logic [7:0]  WP_MAX        = 8'h20;
    // blink timing: half of a 1 s period at 200 MHz
    localparam int          CLK_MHZ       = 200;
    localparam int          BLINK_HALF_MS = 500;
    localparam int          BLINK_HALF_CYC = BLINK_HALF_MS * CLK_MHZ * 1000;
    // register offsets
    localparam logic [7:0]  OFS_DIAG   = 8'h00;
    localparam logic [7:0]  OFS_CTRL   = 8'h04;
    localparam logic [7:0]  OFS_STAT   = 8'h08;
    localparam logic [7:0]  OFS_CLEAR  = 8'h0c;
    localparam logic [7:0]  OFS_ENABLE = 8'h10;
    localparam logic [7:0]  OFS_FLAGS  = 8'h14;
    // ctrl bits and event bits
    localparam int CTRL_ERR_RST = 0;
    localparam int CTRL_DIR_RST = 1;
    localparam int CTRL_BLK_ACK = 2;
    localparam int EVW          = 5;
    localparam int EV_REFUSE    = 0;
    localparam int EV_RANGE     = 1;
    localparam int EV_BLOCK     = 2;
    localparam int EV_FAULT     = 3;
    localparam int EV_CODE      = 4;
    localparam logic [EVW-1:0] EV_RESET = 5'h00;

    // process data taken over by handshake
    typedef struct packed {
        logic [15:0] taught_jaw_position;
        logic [7:0]  clamp_force_setting;
        logic [7:0]  taught_position_window;
        logic [7:0]  profile_select;
        logic [7:0]  workpiece_index;
    } gds_pd_type;

    // lamp pattern states, least severe first
    typedef enum logic [2:0] {
        LAMP_OK      = 3'b000,
        LAMP_WP_LOST = 3'b001,
        LAMP_PD_BAD  = 3'b010,
        LAMP_NO_REF  = 3'b011,
        LAMP_REF_RUN = 3'b100,
        LAMP_SUPPLY  = 3'b101,
        LAMP_INT_ERR = 3'b110
    } gds_lamp_type;
endpackage : gds_pkg

// ---- gds_ctrl_model.sv ----
// controller model that sends move commands and process data
`timescale 1ns/1ps
module gds_ctrl_model (
    input  wire logic           ref_clk,
    input  wire logic           move_accept,
    output logic                move_req,
    output logic                move_dir,
    output logic                handshake,
    output gds_pkg::gds_pd_type pd_in
);
    // ****************************************************************
    // idle levels
    // ****************************************************************
    initial begin
        move_req  = 1'b0;
        move_dir  = 1'b0;
        handshake = 1'b0;
        pd_in     = '0;
    end

    // one move pulse; accept pulses are counted over three cycles
    task automatic move(input logic dir, output int acc);
        acc = 0;
        @(posedge ref_clk);
        move_req <= 1'b1;
        move_dir <= dir;
        @(posedge ref_clk);
        move_req <= 1'b0;
        repeat (3) begin
            #1;
            if (move_accept === 1'b1) acc++;
            @(posedge ref_clk);
        end
    endtask : move

    // new values take effect through the takeover pulse only
    task automatic take_over(input gds_pkg::gds_pd_type pd);
        @(posedge ref_clk);
        pd_in     <= pd;
        handshake <= 1'b1;
        @(posedge ref_clk);
        handshake <= 1'b0;
    endtask : take_over

    // plain rewrite without takeover, to provoke the change codes
    task automatic write_only(input gds_pkg::gds_pd_type pd);
        @(posedge ref_clk);
        pd_in <= pd;
    endtask : write_only
endmodule : gds_ctrl_model

// ---- gds_diag_test.sv ----
// self-checking bench of the diagnosis and status lamp block
`timescale 1ns/1ps
module gds_diag_test;
    // short blink so lamp patterns fit in a few dozen cycles
    localparam int HALF = 8;
    localparam int ON   = 4 * HALF;
    localparam int BL   = 2 * HALF;
    logic                ref_clk;
    logic                rst;
    logic                err_reset;
    logic                dir_flag_reset;
    logic                jaw_blocked;
    logic                block_ack;
    logic [1:0]          flt;
    logic [6:0]          cond;
    logic                move_req;
    logic                move_dir;
    logic                handshake;
    gds_pkg::gds_pd_type pd_in;
    gds_pkg::gds_pd_type base;
    gds_pkg::gds_pd_type p;
    logic                move_accept;
    logic [15:0]         diag_code;
    logic                led_red;
    logic                led_green;
    logic                irq;
    logic [7:0]          addr;
    logic [31:0]         wr_data;
    logic                wr_en;
    logic                rd_en;
    logic [31:0]         rd_data;
    logic [31:0]         d;
    logic [47:0]         mask [5];
    logic [15:0]         chg [5];
    int                  n;
    int                  bad_count;
    int                  checked;

    // ****************************************************************
    // clock, partner and design
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    gds_ctrl_model ctrl_u (.ref_clk(ref_clk), .move_accept(move_accept),
        .move_req(move_req), .move_dir(move_dir), .handshake(handshake),
        .pd_in(pd_in));

    gds_diag #(.HALF_CYCLES(HALF), .WP_LIMIT(gds_pkg::WP_MAX)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .move_req(move_req),
        .move_dir(move_dir), .err_reset(err_reset),
        .dir_flag_reset(dir_flag_reset), .handshake(handshake),
        .pd_in(pd_in), .jaw_blocked(jaw_blocked), .block_ack(block_ack),
        .sys_error(flt[0]), .int_error(cond[5]), .no_prod_params(flt[1]),
        .workpiece_lost(cond[0]), .supply_bad(cond[4]),
        .no_reference(cond[2]), .ref_running(cond[3]),
        .link_only(cond[6]), .pd_invalid(cond[1]),
        .move_accept(move_accept), .diag_code(diag_code),
        .led_red(led_red), .led_green(led_green), .irq(irq),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data));

    // ****************************************************************
    // access and compare tasks
    // ****************************************************************
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk_val

    // diag code is registered from a registered state: allow it to land
    task automatic chk_diag(input logic [15:0] exp);
        repeat (3) @(posedge ref_clk);
        #1;
        chk_val({16'h0000, diag_code}, {16'h0000, exp});
    endtask : chk_diag

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= v;
        wr_en   <= 1'b1;
        @(posedge ref_clk);
        wr_en   <= 1'b0;
        #1;
    endtask : reg_wr

    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        v = rd_data;
    endtask : reg_rd

    // counts lit cycles over two blink periods, whatever the phase
    task automatic lamp_case(input logic [6:0] c, input int er,
                             input int eg, input int es);
        int r;
        int g;
        int s;
        r = 0;
        g = 0;
        s = 0;
        @(posedge ref_clk) cond <= c;
        repeat (4) @(posedge ref_clk);
        repeat (ON) begin
            @(posedge ref_clk);
            #1;
            r += (led_red === 1'b1);
            g += (led_green === 1'b1);
            s += (led_red === led_green);
        end
        chk_val(r, er);
        chk_val(g, eg);
        chk_val(s, es);
    endtask : lamp_case

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    // a hang counts as a mismatch; the run needs about 540 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_of_test();
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        rst = 1'b1;
        err_reset = 1'b0;
        dir_flag_reset = 1'b0;
        jaw_blocked = 1'b0;
        block_ack = 1'b0;
        flt = 2'b00;
        cond = 7'h00;
        addr = 8'h00;
        wr_data = 32'h0000_0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        bad_count = 0;
        checked = 0;
        base = gds_pkg::gds_pd_type'(48'h0123_4010_0503);
        mask = '{48'h0001_0000_0000, 48'h0000_0100_0000,
                 48'h0000_0001_0000, 48'h0000_0000_0100, 48'h0000_0000_0001};
        chg = '{gds_pkg::CODE_CHG_POS, gds_pkg::CODE_CHG_FRC,
                gds_pkg::CODE_CHG_WIN, gds_pkg::CODE_CHG_PRF,
                gds_pkg::CODE_CHG_WP};
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        // restart state holds until the first takeover
        ctrl_u.write_only(base);
        chk_diag(gds_pkg::CODE_RESTART);
        reg_rd(gds_pkg::OFS_DIAG, d);
        chk_val(d, 32'h0000_0312);
        ctrl_u.take_over(base);
        chk_diag(gds_pkg::CODE_READY);
        $display("restart test done");
        // each item changed without takeover, then restored
        for (int i = 0; i < 5; i++) begin
            p = base ^ mask[i];
            ctrl_u.write_only(p);
            chk_diag(chg[i]);
            ctrl_u.write_only(base);
        end
        chk_diag(gds_pkg::CODE_READY);
        p = base;
        p.workpiece_index = 8'h21;
        ctrl_u.take_over(p);
        chk_diag(gds_pkg::CODE_WP_RANGE);
        p.workpiece_index = 8'h20;
        ctrl_u.take_over(p);
        chk_diag(gds_pkg::CODE_READY);
        $display("process data test done");
        // registers: enable readback, clear, unmapped and read-only places
        reg_wr(gds_pkg::OFS_ENABLE, 32'h0000_0003);
        reg_rd(gds_pkg::OFS_ENABLE, d);
        chk_val(d, 32'h0000_0003);
        reg_wr(gds_pkg::OFS_CLEAR, 32'h0000_001f);
        chk_val(irq, 1'b0);
        reg_rd(8'h18, d);
        chk_val(d, 32'h0000_0000);
        reg_wr(gds_pkg::OFS_DIAG, 32'h0000_ffff);
        reg_rd(gds_pkg::OFS_DIAG, d);
        chk_val(d, 32'h0000_0000);
        // direction flag and its three ways out
        ctrl_u.move(1'b0, n);
        chk_val(n, 1);
        ctrl_u.move(1'b0, n);
        chk_val(n, 0);
        chk_diag(gds_pkg::CODE_MOVE_REF);
        reg_rd(gds_pkg::OFS_STAT, d);
        chk_val(d & 32'h1, 32'h1);
        chk_val(irq, 1'b1);
        reg_wr(gds_pkg::OFS_ENABLE, 32'h0000_0000);
        chk_val(irq, 1'b0);
        reg_wr(gds_pkg::OFS_ENABLE, 32'h0000_0001);
        chk_val(irq, 1'b1);
        reg_wr(gds_pkg::OFS_CLEAR, 32'h0000_0001);
        chk_val(irq, 1'b0);
        ctrl_u.move(1'b1, n);
        chk_val(n, 1);
        chk_diag(gds_pkg::CODE_READY);
        ctrl_u.move(1'b1, n);
        chk_val(n, 0);
        @(posedge ref_clk) dir_flag_reset <= 1'b1;
        @(posedge ref_clk) dir_flag_reset <= 1'b0;
        chk_diag(gds_pkg::CODE_READY);
        ctrl_u.move(1'b1, n);
        chk_val(n, 1);
        ctrl_u.move(1'b1, n);
        chk_val(n, 0);
        reg_wr(gds_pkg::OFS_CTRL, 32'h0000_0001);
        chk_diag(gds_pkg::CODE_READY);
        ctrl_u.move(1'b1, n);
        chk_val(n, 1);
        reg_rd(gds_pkg::OFS_FLAGS, d);
        chk_val(d, 32'h0000_0023);
        $display("move test done");
        // blockage stays latched after the jaws free up
        @(posedge ref_clk) jaw_blocked <= 1'b1;
        @(posedge ref_clk) jaw_blocked <= 1'b0;
        chk_diag(gds_pkg::CODE_BLOCKED);
        ctrl_u.move(1'b0, n);
        chk_val(n, 0);
        @(posedge ref_clk) block_ack <= 1'b1;
        @(posedge ref_clk) block_ack <= 1'b0;
        chk_diag(gds_pkg::CODE_MOVE_REF);
        @(posedge ref_clk) err_reset <= 1'b1;
        @(posedge ref_clk) err_reset <= 1'b0;
        chk_diag(gds_pkg::CODE_READY);
        $display("blockage test done");
        // internal faults one by one and overlapping
        @(posedge ref_clk) flt <= 2'b01;
        chk_diag(gds_pkg::CODE_SYS_ERR);
        @(posedge ref_clk) cond <= 7'h20;
        chk_diag(gds_pkg::CODE_SYS_ERR);
        @(posedge ref_clk) flt <= 2'b10;
        chk_diag(gds_pkg::CODE_INT_ERR);
        @(posedge ref_clk) cond <= 7'h00;
        chk_diag(gds_pkg::CODE_NO_PROD);
        @(posedge ref_clk) flt <= 2'b00;
        chk_diag(gds_pkg::CODE_READY);
        $display("fault test done");
        // lamp patterns; bits: link int supply run noref pdbad wplost
        lamp_case(7'h00, 0, ON, 0);
        lamp_case(7'h01, BL, ON, BL);
        lamp_case(7'h10, ON, 0, 0);
        lamp_case(7'h20, BL, 0, BL);
        lamp_case(7'h04, BL, BL, ON);
        lamp_case(7'h08, BL, BL, 0);
        lamp_case(7'h42, BL, ON, BL);
        lamp_case(7'h02, 0, ON, 0);
        lamp_case(7'h31, BL, 0, BL);
        lamp_case(7'h0c, BL, BL, 0);
        $display("lamp test done");
        end_of_test();
    end
endmodule : gds_diag_test
